//--- logic/pcieeh_acc_filt.sv
// Purpose: Decide what a memory or I/O target access really does
// Assumes: Decoded access from the same clock domain
// Notes: Pure decode, registered by the caller
`timescale 1ns/1ps
module pcieeh_acc_filt (
    input wire logic accIsIo,
    input wire logic accWrite,
    input wire logic accAddrPartial,
    input wire logic [3:0] accBe,
    output logic wrEn,
    output logic [3:0] wrBe,
    output logic rdEn,
    output logic rdOnes,
    output logic cplOnly
);
    logic beNone;
    logic beFull;
    assign beNone = (accBe == 4'h0);
    assign beFull = (accBe == 4'hf);
    // ============
    // Decode; no path here raises an error
    always_comb begin
        wrEn = 1'b0;
        wrBe = accBe;
        rdEn = 1'b0;
        rdOnes = 1'b0;
        cplOnly = 1'b0;
        if (accIsIo) begin
            if (accAddrPartial) begin
                rdOnes = !accWrite;
            end else if (accWrite) begin
                wrEn = beFull;
            end else begin
                rdEn = 1'b1;
            end
        end else if (accWrite) begin
            // Byte enables honoured when partial nothing on zero length
            wrEn = !beNone;
        end else begin
            rdEn = !beNone;
            cplOnly = beNone;
        end
    end
endmodule

//--- logic/pcieeh_err_log.sv
// Purpose: Error status, first error pointer and header log
// Assumes: At most one error event per cycle
// Notes: Hardware set wins over a same-cycle software clear
`timescale 1ns/1ps
module pcieeh_err_log
    import pcieeh_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic evt,
    input wire logic adv,
    input wire logic [2:0] idx,
    input wire logic [31:0] hdr,
    input wire logic advMask,
    input wire logic [pcieeh_pkg::NERR-1:0] uncMask,
    input wire logic clrCor,
    input wire logic [pcieeh_pkg::NERR-1:0] clrUnc,
    output logic corAdv,
    output logic [pcieeh_pkg::NERR-1:0] unc,
    output logic [2:0] fep,
    output logic logValid,
    output logic [31:0] hdrLog
);
    import pcieeh_pkg::*;
    typedef struct packed {
        logic corAdv;
        logic [NERR-1:0] unc;
        logic [2:0] fep;
        logic logValid;
        logic [31:0] hdrLog;
    } pcieeh_log_t;
    pcieeh_log_t s_r;
    pcieeh_log_t s_nxt;
    logic [NERR-1:0] hit;
    assign hit = NERR'(1) << idx;
    always_comb begin
        s_nxt = s_r;
        if (clrCor) begin
            s_nxt.corAdv = 1'b0;
        end
        s_nxt.unc = s_r.unc & ~clrUnc;
        // Freeing the pointed-to status frees the log
        if ((clrUnc & (NERR'(1) << s_r.fep)) != '0) begin
            s_nxt.logValid = 1'b0;
        end
        if (evt) begin
            if (adv) begin
                s_nxt.corAdv = 1'b1;
            end
            if (!adv || !advMask) begin
                s_nxt.unc = s_nxt.unc | hit;
                if (((uncMask & hit) == '0) && !s_r.logValid) begin
                    s_nxt.fep = idx;
                    s_nxt.hdrLog = hdr;
                    s_nxt.logValid = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign corAdv = s_r.corAdv;
    assign unc = s_r.unc;
    assign fep = s_r.fep;
    assign logValid = s_r.logValid;
    assign hdrLog = s_r.hdrLog;
endmodule

//--- logic/pcieeh_pkg.sv
// Purpose: Shared constants for the endpoint error handling block
// Assumes: Byte offsets on a plain register port, 32-bit data
// Notes: One aligned word per register
package pcieeh_pkg;
    // ============
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PCFG = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_SEV = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_COR = 8'h14;
    localparam logic [7:0] REG_UNC = 8'h18;
    localparam logic [7:0] REG_HDR = 8'h1c;
    localparam logic [7:0] REG_CAP = 8'h20;
    // ============
    // Control bits
    localparam int CTL_DEVRST = 0;
    localparam int CTL_ECRCGEN = 1;
    localparam int CTL_ECRCCHK = 2;
    localparam int CTL_SERR = 3;
    localparam int CTL_URREP = 4;
    localparam int CTL_CORREP = 5;
    localparam int CTL_NFREP = 6;
    localparam int CTL_FREP = 7;
    // ============
    // Error indices, shared by mask, severity and status
    localparam int NERR = 5;
    localparam logic [2:0] ERR_POISON = 3'h0;
    localparam logic [2:0] ERR_TIMEOUT = 3'h1;
    localparam logic [2:0] ERR_URCA = 3'h2;
    localparam logic [2:0] ERR_UNEXP = 3'h3;
    localparam logic [2:0] ERR_ECRC = 3'h4;
    // ============
    // Mask, status and capability fields
    localparam int MSK_ADV = 8;
    localparam int MSK_ABR = 9;
    localparam int MSK_CPLF = 10;
    localparam int ST_ABORT = 0;
    localparam int ST_CPLF = 1;
    localparam int ST_HALT = 2;
    localparam int ST_LOGV = 3;
    localparam int ST_FEP = 4;
    localparam int CAP_ROLE = 0;
    localparam int CAP_GEN = 1;
    localparam int CAP_CHK = 2;
    // ============
    // Reset values and codes
    localparam int RETRY_W = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [RETRY_W-1:0] PCFG_RST = 4'h2;
    localparam logic [10:0] MASK_RST = 11'h000;
    localparam logic [NERR-1:0] SEV_RST = 5'h00;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] CPL_CA = 3'h4;
endpackage

//--- logic/pcieeh_top.sv
// Purpose: Transaction-layer error handling of a PCIe endpoint function
// Assumes: Receive, timeout and access events are one-cycle strobes on clk
// Notes: One error event is logged per cycle, in fixed priority
//
// What this block does
// - Poisoned TLP is retried up to the programmed count, then dropped.
// - After poison failure, master requests stop until device reset.
// - ECRC appended to transmitted TLPs when generation enabled; capability from memory.
// - ECRC checked when check enabled; check capability from memory.
// - TLP failing ECRC is discarded and reported.
// - Zero-length memory write changes nothing and succeeds silently.
// - Partial memory read acts as a full read with its side effects.
// - Zero-length memory read completes without touching the register.
// - No error for partial or zero-length memory accesses.
// - I/O partial on address: write discarded, read returns all ones.
// - I/O partial on data only: write discarded, read performed.
// - Lower layer error suppresses higher layer reports for that packet.
// - Unsuccessful completion is dropped and raises an interrupt when mask bit MSK_CPLF is set.
// - Role-based error reporting capability reads as one.
// - System-error enable also enables unsupported-request reporting.
// - Advisory error sets advisory status, then consults advisory mask.
// - Unmasked advisory sets uncorrectable status and logs if log free.
// - Advisory error sends correctable message only if enabled, never non-fatal.
// - Non-fatal UR/CA, retried timeout, poison, unexpected completion are advisory.
// - UR or CA on DMA halts mastering, sets abort flag, maybe interrupts.
// - Device reset bit resumes mastering, flushes link work, resets port.
// - Non-fatal timeout retried once with advisory; second failure uncorrectable.
`timescale 1ns/1ps
module pcieeh_top
    import pcieeh_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic nvmCapLoad,
    input wire logic nvmEcrcGenCap,
    input wire logic nvmEcrcChkCap,
    input wire logic rxValid,
    input wire logic rxPhyErr,
    input wire logic rxDllErr,
    input wire logic rxEcrcErr,
    input wire logic rxPoison,
    input wire logic rxIsCpl,
    input wire logic rxUnexpected,
    input wire logic rxDma,
    input wire logic [2:0] rxCplStatus,
    input wire logic [31:0] rxHeader,
    input wire logic cplTimeout,
    input wire logic accValid,
    input wire logic accIsIo,
    input wire logic accWrite,
    input wire logic accAddrPartial,
    input wire logic [3:0] accBe,
    output logic rxDeliver,
    output logic rxDrop,
    output logic poisonRetry,
    output logic cplReissue,
    output logic masterEn,
    output logic portReset,
    output logic txEcrcAppend,
    output logic ecrcCheckOn,
    output logic irqReq,
    output logic msgCor,
    output logic msgNonFatal,
    output logic msgFatal,
    output logic phyErrRep,
    output logic dllErrRep,
    output logic accWrEn,
    output logic [3:0] accWrBe,
    output logic accRdEn,
    output logic accRdOnes,
    output logic accCplOnly
);
    import pcieeh_pkg::*;
    // ============
    // State
    typedef struct packed {
        logic [7:0] ctrl;
        logic [RETRY_W-1:0] pcfg;
        logic [10:0] mask;
        logic [NERR-1:0] sev;
        logic [RETRY_W-1:0] pcnt;
        logic abortFlag;
        logic cplFail;
        logic masterOn;
        logic capGen;
        logic capChk;
        logic toRetried;
        logic portRst;
        logic [31:0] rdata;
        logic deliver;
        logic drop;
        logic pRetry;
        logic reissue;
        logic irq;
        logic mCor;
        logic mNf;
        logic mF;
        logic phyRep;
        logic dllRep;
        logic wrEn;
        logic [3:0] wrBe;
        logic rdEn;
        logic rdOnes;
        logic cplOnly;
    } pcieeh_st_t;
    localparam pcieeh_st_t ST_RST = '{
        ctrl: CTRL_RST, pcfg: PCFG_RST, mask: MASK_RST, sev: SEV_RST,
        masterOn: 1'b1, default: '0};
    pcieeh_st_t s_r;
    pcieeh_st_t s_nxt;
    // ============
    // Helpers and submodules
    logic fWrEn;
    logic [3:0] fWrBe;
    logic fRdEn;
    logic fRdOnes;
    logic fCplOnly;
    logic logEvt;
    logic logAdv;
    logic [2:0] logIdx;
    logic clrCor;
    logic [NERR-1:0] clrUnc;
    logic corAdv;
    logic [NERR-1:0] uncSt;
    logic [2:0] fep;
    logic logValid;
    logic [31:0] hdrLog;
    logic logRst;
    assign logRst = rst | s_r.portRst;
    assign clrCor = regWr && (regAddr == REG_COR) && regWdata[0];
    assign clrUnc = (regWr && (regAddr == REG_UNC)) ? regWdata[NERR-1:0] : '0;
    pcieeh_acc_filt u_filt (
        .accIsIo(accIsIo),
        .accWrite(accWrite),
        .accAddrPartial(accAddrPartial),
        .accBe(accBe),
        .wrEn(fWrEn),
        .wrBe(fWrBe),
        .rdEn(fRdEn),
        .rdOnes(fRdOnes),
        .cplOnly(fCplOnly)
    );
    pcieeh_err_log u_log (
        .clk(clk),
        .rst(logRst),
        .evt(logEvt),
        .adv(logAdv),
        .idx(logIdx),
        .hdr(rxHeader),
        .advMask(s_r.mask[MSK_ADV]),
        .uncMask(s_r.mask[NERR-1:0]),
        .clrCor(clrCor),
        .clrUnc(clrUnc),
        .corAdv(corAdv),
        .unc(uncSt),
        .fep(fep),
        .logValid(logValid),
        .hdrLog(hdrLog)
    );
    // ============
    // Receive path classification
    logic tlOk;
    logic ecrcBad;
    logic poisonEv;
    logic unexpEv;
    logic cplBad;
    logic urcaEv;
    logic toEv;
    logic corEn;
    logic nfEn;
    logic fEn;
    logic urEn;
    // Lower layer error hides the packet from upper layers
    assign tlOk = rxValid && !rxPhyErr && !rxDllErr;
    assign ecrcBad = tlOk && s_r.ctrl[CTL_ECRCCHK] && rxEcrcErr;
    assign poisonEv = tlOk && !ecrcBad && rxPoison;
    assign unexpEv = tlOk && !ecrcBad && !rxPoison && rxIsCpl && rxUnexpected;
    assign cplBad = tlOk && !ecrcBad && !rxPoison && rxIsCpl && !rxUnexpected
        && (rxCplStatus != 3'h0);
    assign urcaEv = cplBad && ((rxCplStatus == CPL_UR) || (rxCplStatus == CPL_CA));
    assign toEv = cplTimeout;
    assign corEn = s_r.ctrl[CTL_CORREP] || s_r.ctrl[CTL_SERR];
    assign nfEn = s_r.ctrl[CTL_NFREP] || s_r.ctrl[CTL_SERR];
    assign fEn = s_r.ctrl[CTL_FREP] || s_r.ctrl[CTL_SERR];
    assign urEn = s_r.ctrl[CTL_URREP] || s_r.ctrl[CTL_SERR];
    // ============
    // Next state
    always_comb begin
        logic unmasked;
        logic fatalSev;
        unmasked = 1'b0;
        fatalSev = 1'b0;
        s_nxt = s_r;
        logEvt = 1'b0;
        logAdv = 1'b0;
        logIdx = ERR_POISON;
        s_nxt.rdata = '0;
        s_nxt.portRst = 1'b0;
        s_nxt.deliver = 1'b0;
        s_nxt.drop = 1'b0;
        s_nxt.pRetry = 1'b0;
        s_nxt.reissue = 1'b0;
        s_nxt.irq = 1'b0;
        s_nxt.mCor = 1'b0;
        s_nxt.mNf = 1'b0;
        s_nxt.mF = 1'b0;
        s_nxt.phyRep = rxValid && rxPhyErr;
        s_nxt.dllRep = rxValid && rxDllErr && !rxPhyErr;
        // Target access decode; halt never blocks register service
        s_nxt.wrEn = accValid && fWrEn;
        s_nxt.wrBe = fWrBe;
        s_nxt.rdEn = accValid && fRdEn;
        s_nxt.rdOnes = accValid && fRdOnes;
        s_nxt.cplOnly = accValid && fCplOnly;
        if (nvmCapLoad) begin
            s_nxt.capGen = nvmEcrcGenCap;
            s_nxt.capChk = nvmEcrcChkCap;
        end
        // Software writes first so hardware sets below win
        if (regWr) begin
            case (regAddr)
                REG_CTRL: s_nxt.ctrl = regWdata[7:0] & ~8'h01;
                REG_PCFG: s_nxt.pcfg = regWdata[RETRY_W-1:0];
                REG_MASK: s_nxt.mask = regWdata[10:0];
                REG_SEV: s_nxt.sev = regWdata[NERR-1:0];
                REG_STAT: begin
                    if (regWdata[ST_ABORT]) begin
                        s_nxt.abortFlag = 1'b0;
                    end
                    if (regWdata[ST_CPLF]) begin
                        s_nxt.cplFail = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                REG_CTRL: s_nxt.rdata = {24'h000000, s_r.ctrl};
                REG_PCFG: s_nxt.rdata = {28'h0000000, s_r.pcfg};
                REG_MASK: s_nxt.rdata = {21'h000000, s_r.mask};
                REG_SEV: s_nxt.rdata = {27'h0000000, s_r.sev};
                REG_STAT: s_nxt.rdata = {25'h0000000, fep, logValid, !s_r.masterOn,
                    s_r.cplFail, s_r.abortFlag};
                REG_COR: s_nxt.rdata = {31'h00000000, corAdv};
                REG_UNC: s_nxt.rdata = {27'h0000000, uncSt};
                REG_HDR: s_nxt.rdata = hdrLog;
                // Role-based reporting always advertised
                REG_CAP: s_nxt.rdata = {29'h00000000, s_r.capChk, s_r.capGen, 1'b1};
                default: s_nxt.rdata = '0;
            endcase
        end
        // Good packets pass; every error path drops except a poison retry
        s_nxt.deliver = tlOk && !ecrcBad && !poisonEv && !unexpEv && !cplBad;
        s_nxt.drop = rxValid && !s_nxt.deliver && !poisonEv;
        if (s_nxt.deliver) begin
            s_nxt.pcnt = '0;
        end
        if (s_nxt.deliver && rxIsCpl) begin
            s_nxt.toRetried = 1'b0;
        end
        // Single logger slot: ECRC, poison, unexpected, UR/CA, timeout
        if (ecrcBad) begin
            logEvt = 1'b1;
            logIdx = ERR_ECRC;
        end else if (poisonEv) begin
            logEvt = 1'b1;
            logIdx = ERR_POISON;
            if (s_r.pcnt < s_r.pcfg) begin
                s_nxt.pRetry = 1'b1;
                s_nxt.pcnt = s_r.pcnt + 1'b1;
            end else begin
                s_nxt.drop = 1'b1;
                s_nxt.masterOn = 1'b0;
                s_nxt.pcnt = '0;
            end
        end else if (unexpEv) begin
            logEvt = 1'b1;
            logIdx = ERR_UNEXP;
        end else if (urcaEv) begin
            logEvt = 1'b1;
            logIdx = ERR_URCA;
        end else if (toEv) begin
            logEvt = 1'b1;
            logIdx = ERR_TIMEOUT;
        end
        // Non-fatal severity makes these advisory, except ECRC and a second timeout
        fatalSev = s_r.sev[logIdx];
        logAdv = logEvt && !fatalSev && (logIdx != ERR_ECRC);
        if (logEvt && (logIdx == ERR_TIMEOUT) && !fatalSev) begin
            if (!s_r.toRetried) begin
                s_nxt.reissue = 1'b1;
                s_nxt.toRetried = 1'b1;
            end else begin
                logAdv = 1'b0;
                s_nxt.toRetried = 1'b0;
            end
        end
        unmasked = !s_r.mask[logIdx];
        if (logEvt && logAdv) begin
            s_nxt.mCor = corEn;
        end else if (logEvt && unmasked) begin
            if (logIdx == ERR_URCA) begin
                s_nxt.mNf = !fatalSev && urEn && nfEn;
                s_nxt.mF = fatalSev && urEn && fEn;
            end else begin
                s_nxt.mNf = !fatalSev && nfEn;
                s_nxt.mF = fatalSev && fEn;
            end
        end
        if (cplBad) begin
            s_nxt.cplFail = 1'b1;
            s_nxt.irq = s_r.mask[MSK_CPLF];
        end
        if (urcaEv && rxDma) begin
            s_nxt.masterOn = 1'b0;
            s_nxt.abortFlag = 1'b1;
            s_nxt.irq = s_nxt.irq || s_r.mask[MSK_ABR];
        end
        // Device reset flushes the port and releases the master
        if (regWr && (regAddr == REG_CTRL) && regWdata[CTL_DEVRST]) begin
            s_nxt = ST_RST;
            s_nxt.capGen = s_r.capGen;
            s_nxt.capChk = s_r.capChk;
            s_nxt.portRst = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ============
    // Outputs, all flops
    assign regRdata = s_r.rdata;
    assign rxDeliver = s_r.deliver;
    assign rxDrop = s_r.drop;
    assign poisonRetry = s_r.pRetry;
    assign cplReissue = s_r.reissue;
    assign masterEn = s_r.masterOn;
    assign portReset = s_r.portRst;
    assign txEcrcAppend = s_r.ctrl[CTL_ECRCGEN];
    assign ecrcCheckOn = s_r.ctrl[CTL_ECRCCHK];
    assign irqReq = s_r.irq;
    assign msgCor = s_r.mCor;
    assign msgNonFatal = s_r.mNf;
    assign msgFatal = s_r.mF;
    assign phyErrRep = s_r.phyRep;
    assign dllErrRep = s_r.dllRep;
    assign accWrEn = s_r.wrEn;
    assign accWrBe = s_r.wrBe;
    assign accRdEn = s_r.rdEn;
    assign accRdOnes = s_r.rdOnes;
    assign accCplOnly = s_r.cplOnly;
endmodule

//--- test/pcieeh_rc_model.sv
// Purpose: Upstream port that sends received-packet events
// Assumes: Events are one-cycle strobes with level qualifiers
// Notes: Qualifiers scrambled between events
`timescale 1ns/1ps
module pcieeh_rc_model (
    input wire logic clk,
    output logic rxValid,
    output logic rxPhyErr,
    output logic rxDllErr,
    output logic rxEcrcErr,
    output logic rxPoison,
    output logic rxIsCpl,
    output logic rxUnexpected,
    output logic rxDma,
    output logic [2:0] rxCplStatus,
    output logic [31:0] rxHeader
);
    initial begin
        {rxValid, rxDma, rxUnexpected, rxIsCpl, rxPoison, rxEcrcErr, rxDllErr, rxPhyErr} = '0;
        {rxCplStatus, rxHeader} = '0;
    end
    // ============
    // One packet; q is {dma, unexpected, cpl, poison, ecrc, dll, phy}
    task automatic tlp(input logic [6:0] q, input logic [2:0] st);
        @(posedge clk);
        rxValid <= 1'b1;
        {rxDma, rxUnexpected, rxIsCpl, rxPoison, rxEcrcErr, rxDllErr, rxPhyErr} <= q;
        rxCplStatus <= st;
        rxHeader <= {25'h0, q};
        @(posedge clk);
        rxValid <= 1'b0;
        {rxDma, rxUnexpected, rxIsCpl, rxPoison, rxEcrcErr, rxDllErr, rxPhyErr} <= ~q;
        rxCplStatus <= ~st;
        rxHeader <= ~{25'h0, q};
        #1;
    endtask
endmodule

//--- test/pcieeh_top_assertions.sv
// Purpose: Port-level checks on the error handling top
// Assumes: One clock, synchronous active-high reset
// Notes: Outputs judged one cycle after their cause
`timescale 1ns/1ps
module pcieeh_top_assertions
    import pcieeh_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic rxValid,
    input wire logic rxPhyErr,
    input wire logic rxDllErr,
    input wire logic rxEcrcErr,
    input wire logic accValid,
    input wire logic accIsIo,
    input wire logic accWrite,
    input wire logic accAddrPartial,
    input wire logic [3:0] accBe,
    input wire logic rxDeliver,
    input wire logic rxDrop,
    input wire logic masterEn,
    input wire logic portReset,
    input wire logic txEcrcAppend,
    input wire logic ecrcCheckOn,
    input wire logic msgCor,
    input wire logic msgNonFatal,
    input wire logic phyErrRep,
    input wire logic dllErrRep,
    input wire logic accWrEn,
    input wire logic accRdEn,
    input wire logic accRdOnes,
    input wire logic accCplOnly
);
    // ============
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    phy_first_a: assert property (rxValid && rxPhyErr |=> phyErrRep && !dllErrRep && !rxDeliver)
        else $error("phy error not isolated");
    dll_first_a: assert property (rxValid && rxDllErr && !rxPhyErr |=>
        dllErrRep && rxDrop && !msgCor && !msgNonFatal) else $error("link error not isolated");
    ecrc_drop_a: assert property (rxValid && rxEcrcErr && ecrcCheckOn && !rxPhyErr && !rxDllErr
        |=> rxDrop && !rxDeliver) else $error("bad ecrc packet kept");
    zero_write_a: assert property (accValid && !accIsIo && accWrite && accBe == 4'h0
        |=> !accWrEn && !msgCor && !msgNonFatal) else $error("zero write had effect");
    part_read_a: assert property (accValid && !accIsIo && !accWrite && accBe != 4'h0
        |=> accRdEn && !accRdOnes) else $error("partial read not full");
    zero_read_a: assert property (accValid && !accIsIo && !accWrite && accBe == 4'h0
        |=> accCplOnly && !accRdEn) else $error("zero read touched register");
    io_addr_a: assert property (accValid && accIsIo && accAddrPartial
        |=> !accWrEn && accRdOnes == !$past(accWrite)) else $error("io address partial wrong");
    io_data_a: assert property (accValid && accIsIo && !accAddrPartial && accBe != 4'hf
        |=> !accWrEn && accRdEn == !$past(accWrite)) else $error("io data partial wrong");
    halt_until_a: assert property ($rose(masterEn) |-> portReset || $past(portReset))
        else $error("mastering resumed without reset");
    gen_follow_a: assert property (regWr && regAddr == REG_CTRL && !regWdata[CTL_DEVRST]
        ##1 !(regWr && regAddr == REG_CTRL) |=> txEcrcAppend == $past(regWdata[CTL_ECRCGEN], 2)
        && ecrcCheckOn == $past(regWdata[CTL_ECRCCHK], 2)) else $error("ecrc enables wrong");
    cover property ($rose(masterEn));
    cover property (accValid && accIsIo ##1 accRdOnes);
    cover property (rxValid && rxDllErr ##1 dllErrRep);
endmodule
bind pcieeh_top pcieeh_top_assertions i_chk (.*);

//--- test/pcieeh_top_test.sv
// Purpose: Self-checking bench for the error handling top
// Assumes: 25 MHz clock, reset held two cycles
// Notes: Each scenario checks outputs one cycle after its event
`timescale 1ns/1ps
module pcieeh_top_test;
    import pcieeh_pkg::*;
    logic clk, rst, regWr, regRd, nvmCapLoad, nvmEcrcGenCap, nvmEcrcChkCap, cplTimeout;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rxHeader;
    logic rxValid, rxPhyErr, rxDllErr, rxEcrcErr, rxPoison, rxIsCpl, rxUnexpected, rxDma;
    logic [2:0] rxCplStatus;
    logic accValid, accIsIo, accWrite, accAddrPartial;
    logic [3:0] accBe, accWrBe;
    logic rxDeliver, rxDrop, poisonRetry, cplReissue, masterEn, portReset, txEcrcAppend;
    logic ecrcCheckOn, irqReq, msgCor, msgNonFatal, msgFatal, phyErrRep, dllErrRep;
    logic accWrEn, accRdEn, accRdOnes, accCplOnly;
    int mismatches = 0;
    int comparisons = 0;
    // Access table: {io, write, addrPartial, be, wrEn, rdEn, rdOnes, cplOnly}
    localparam logic [10:0] ACC [9] = '{11'b0100000_0000, 11'b0100011_1000,
        11'b0000001_0100, 11'b0000000_0001, 11'b1111111_0000, 11'b1011111_0010,
        11'b1100011_0000, 11'b1000011_0100, 11'b1101111_1000};
    pcieeh_top i_dut (.*);
    pcieeh_rc_model i_rc (.*);
    // ============
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    task automatic dev_reset;
        wr(REG_CTRL, 32'h1);
        chk({30'h0, portReset, masterEn}, 32'h3);
        step;
        chk({30'h0, portReset, masterEn}, 32'h1);
    endtask
    // ============
    // Scenarios
    task automatic t_regs;
        rc(REG_CAP, 32'h1);
        rc(REG_PCFG, {28'h0, PCFG_RST});
        rc(8'h40, 32'h0);
        @(posedge clk);
        nvmEcrcGenCap <= 1'b1;
        nvmCapLoad <= 1'b1;
        @(posedge clk);
        nvmCapLoad <= 1'b0;
        nvmEcrcGenCap <= 1'b0;
        rc(REG_CAP, 32'h3);
    endtask
    task automatic t_ecrc;
        wr(REG_CTRL, 32'h26);
        chk({30'h0, txEcrcAppend, ecrcCheckOn}, 32'h3);
        i_rc.tlp(7'b0000100, 3'h0);
        chk({30'h0, rxDrop, rxDeliver}, 32'h2);
        i_rc.tlp(7'b0000000, 3'h0);
        chk({30'h0, rxDrop, rxDeliver}, 32'h1);
        i_rc.tlp(7'b0000111, 3'h0);
        chk({28'h0, phyErrRep, dllErrRep, rxDeliver, msgCor}, 32'h8);
        i_rc.tlp(7'b0001010, 3'h0);
        chk({27'h0, phyErrRep, dllErrRep, rxDrop, msgCor, masterEn}, 32'hd);
    endtask
    task automatic t_access;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            accValid <= 1'b1;
            {accIsIo, accWrite, accAddrPartial, accBe} <= ACC[i][10:4];
            @(posedge clk);
            accValid <= 1'b0;
            {accIsIo, accWrite, accAddrPartial, accBe} <= ~ACC[i][10:4];
            #1;
            chk({22'h0, accWrBe, accWrEn, accRdEn, accRdOnes, accCplOnly, msgCor, msgNonFatal},
                {22'h0, ACC[i][7:4], ACC[i][3:0], 2'b00});
        end
    endtask
    task automatic t_poison;
        dev_reset;
        wr(REG_CTRL, 32'h20);
        for (int i = 0; i < 3; i++) begin
            i_rc.tlp(7'b1001000, 3'h0);
            chk({29'h0, poisonRetry, rxDrop, masterEn}, (i < 2) ? 32'h5 : 32'h2);
        end
        chk({30'h0, msgCor, msgNonFatal}, 32'h2);
        rc(REG_COR, 32'h1);
        rc(REG_UNC, 32'h1);
        rc(REG_STAT, 32'hc);
        rc(REG_HDR, 32'h48);
        dev_reset;
        rc(REG_STAT, 32'h0);
    endtask
    task automatic t_urca;
        wr(REG_MASK, 32'h200);
        wr(REG_CTRL, 32'h08);
        i_rc.tlp(7'b1010000, CPL_UR);
        chk({27'h0, rxDeliver, irqReq, masterEn, msgCor, msgNonFatal}, 32'ha);
        rc(REG_STAT, 32'h2f);
        dev_reset;
        wr(REG_CTRL, 32'h20);
        i_rc.tlp(7'b1010000, CPL_CA);
        chk({28'h0, rxDeliver, irqReq, masterEn, msgCor}, 32'h1);
        dev_reset;
    endtask
    task automatic t_timeout;
        wr(REG_CTRL, 32'h60);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            cplTimeout <= 1'b1;
            @(posedge clk);
            cplTimeout <= 1'b0;
            #1;
            chk({28'h0, cplReissue, msgCor, msgNonFatal, msgFatal}, (i == 0) ? 32'hc : 32'h2);
        end
    endtask
    // ============
    // Clock, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {regWr, regRd, nvmCapLoad, nvmEcrcGenCap, nvmEcrcChkCap, cplTimeout} = 6'h00;
        {regAddr, regWdata} = 40'h0;
        {accValid, accIsIo, accWrite, accAddrPartial, accBe} = 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_ecrc;
        t_access;
        t_poison;
        t_urca;
        t_timeout;
        complete_run;
    end
    // Run is under a hundred cycles; wide margin
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        complete_run;
    end
endmodule
